// ### src/ppfs_top.sv
// ppfs_top: per-pin function select for ports 0 to 3
// assumes peripherals present out/oe per function slot and read periph_in;
// pin levels arrive asynchronously and are synchronised here
`timescale 1ns/1ns
module ppfs_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  input  wire logic [ppfs_pkg::AW-1:0]       s_axil_awaddr,
  input  wire logic                          s_axil_awvalid,
  output logic                               s_axil_awready,
  input  wire logic [31:0]                   s_axil_wdata,
  input  wire logic [3:0]                    s_axil_wstrb,
  input  wire logic                          s_axil_wvalid,
  output logic                               s_axil_wready,
  output logic [1:0]                         s_axil_bresp,
  output logic                               s_axil_bvalid,
  input  wire logic                          s_axil_bready,
  input  wire logic [ppfs_pkg::AW-1:0]       s_axil_araddr,
  input  wire logic                          s_axil_arvalid,
  output logic                               s_axil_arready,
  output logic [31:0]                        s_axil_rdata,
  output logic [1:0]                         s_axil_rresp,
  output logic                               s_axil_rvalid,
  input  wire logic                          s_axil_rready,
  input  wire logic [ppfs_pkg::NPINS-1:0]    pin_in,
  output logic      [ppfs_pkg::NPINS-1:0]    pin_out,
  output logic      [ppfs_pkg::NPINS-1:0]    pin_oe,
  input  wire logic [ppfs_pkg::NFUNC-1:0]    periph_out,
  input  wire logic [ppfs_pkg::NFUNC-1:0]    periph_oe,
  output logic      [ppfs_pkg::NFUNC-1:0]    periph_in,
  output logic      [ppfs_pkg::NIRQ-1:0]     ext_irq,
  output logic      [ppfs_pkg::NPINS-1:0]    analog_en
);
  localparam int NP = ppfs_pkg::NPINS;
  localparam int NF = ppfs_pkg::NFUNC;
  localparam int FW = ppfs_pkg::FW;

  ////////////////////////////////////////////////////////////////////////////
  // code to function slot, {valid, slot}

  // pin is the index in the package pin order
  function automatic logic [FW:0] route(input logic [4:0] pin, input logic [FW-1:0] code);
    logic [FW:0] r;
    r = '0;
    case ({pin, code})
      // (R4) port 0 pin 0 routes
      {5'd0, ppfs_pkg::FC_07}:  r = {1'b1, ppfs_pkg::F_CLK_ACC_REF};
      {5'd0, ppfs_pkg::FC_09}:  r = {1'b1, ppfs_pkg::F_CONV1_START};
      {5'd0, ppfs_pkg::FC_1E}:  r = {1'b1, ppfs_pkg::F_COMPARATOR0_OUT};
      // (R21) timer 9 signal A
      {5'd0, ppfs_pkg::FC_01}:  r = {1'b1, ppfs_pkg::F_MF9_A};
      {5'd0, ppfs_pkg::FC_03}:  r = {1'b1, ppfs_pkg::F_MF9_A_ALT};
      // (R5) port 0 pin 1 routes
      {5'd1, ppfs_pkg::FC_07}:  r = {1'b1, ppfs_pkg::F_OUT_DIS12};
      {5'd1, ppfs_pkg::FC_09}:  r = {1'b1, ppfs_pkg::F_CONV2_START};
      {5'd1, ppfs_pkg::FC_14}:  r = {1'b1, ppfs_pkg::F_PWM_TRIG_A};
      {5'd1, ppfs_pkg::FC_15}:  r = {1'b1, ppfs_pkg::F_PWM_TRIG_B};
      {5'd1, ppfs_pkg::FC_16}:  r = {1'b1, ppfs_pkg::F_PWM_TRIG_C};
      {5'd1, ppfs_pkg::FC_17}:  r = {1'b1, ppfs_pkg::F_PWM_TRIG_D};
      // (R6) port 1 pin 0 routes
      {5'd2, ppfs_pkg::FC_02}:  r = {1'b1, ppfs_pkg::F_MF_CLK_D};
      {5'd2, ppfs_pkg::FC_04}:  r = {1'b1, ppfs_pkg::F_MF_CLK_D_ALT};
      {5'd2, ppfs_pkg::FC_05}:  r = {1'b1, ppfs_pkg::F_BT3_RESET};
      {5'd2, ppfs_pkg::FC_07}:  r = {1'b1, ppfs_pkg::F_OUT_DIS12};
      {5'd2, ppfs_pkg::FC_15}:  r = {1'b1, ppfs_pkg::F_PWM_TRIG_B};
      {5'd2, ppfs_pkg::FC_17}:  r = {1'b1, ppfs_pkg::F_PWM_TRIG_D};
      // (R7) port 1 pin 1 routes
      {5'd3, ppfs_pkg::FC_05}:  r = {1'b1, ppfs_pkg::F_BT3_OUT};
      {5'd3, ppfs_pkg::FC_07}:  r = {1'b1, ppfs_pkg::F_OUT_DIS9};
      {5'd3, ppfs_pkg::FC_08}:  r = {1'b1, ppfs_pkg::F_MF9_D};
      {5'd3, ppfs_pkg::FC_15}:  r = {1'b1, ppfs_pkg::F_PWM_TRIG_A};
      {5'd3, ppfs_pkg::FC_17}:  r = {1'b1, ppfs_pkg::F_PWM_TRIG_C};
      // (R8) port 1 pins 2 to 4 PWM routes
      {5'd4, ppfs_pkg::FC_14}:  r = {1'b1, ppfs_pkg::F_PWM0_A};
      {5'd4, ppfs_pkg::FC_15}:  r = {1'b1, ppfs_pkg::F_PWM7_A};
      {5'd4, ppfs_pkg::FC_16}:  r = {1'b1, ppfs_pkg::F_PWM0_A_ALT};
      {5'd5, ppfs_pkg::FC_14}:  r = {1'b1, ppfs_pkg::F_PWM1_A};
      {5'd5, ppfs_pkg::FC_15}:  r = {1'b1, ppfs_pkg::F_PWM8_A};
      {5'd5, ppfs_pkg::FC_16}:  r = {1'b1, ppfs_pkg::F_PWM1_A_ALT};
      {5'd6, ppfs_pkg::FC_14}:  r = {1'b1, ppfs_pkg::F_PWM2_A};
      {5'd6, ppfs_pkg::FC_15}:  r = {1'b1, ppfs_pkg::F_PWM9_A};
      {5'd6, ppfs_pkg::FC_16}:  r = {1'b1, ppfs_pkg::F_PWM2_A_ALT};
      // (R9) port 2 pin 0 routes
      {5'd10, ppfs_pkg::FC_05}: r = {1'b1, ppfs_pkg::F_BT4_RESET};
      {5'd10, ppfs_pkg::FC_09}: r = {1'b1, ppfs_pkg::F_CONV0_TRIG};
      {5'd10, ppfs_pkg::FC_0D}: r = {1'b1, ppfs_pkg::F_SPI_A_CLK};
      // (R10) port 2 pin 1 routes
      {5'd11, ppfs_pkg::FC_01}: r = {1'b1, ppfs_pkg::F_MF9_A};
      {5'd11, ppfs_pkg::FC_03}: r = {1'b1, ppfs_pkg::F_MF9_A_ALT};
      {5'd11, ppfs_pkg::FC_05}: r = {1'b1, ppfs_pkg::F_BT4_CLK};
      {5'd11, ppfs_pkg::FC_0D}: r = {1'b1, ppfs_pkg::F_SPI_A_MOSI};
      {5'd11, ppfs_pkg::FC_1E}: r = {1'b1, ppfs_pkg::F_COMPARATOR5_OUT};
      // (R11) port 2 pin 2 routes
      {5'd12, ppfs_pkg::FC_02}: r = {1'b1, ppfs_pkg::F_MF_CLK_D};
      {5'd12, ppfs_pkg::FC_04}: r = {1'b1, ppfs_pkg::F_MF_CLK_D_ALT};
      {5'd12, ppfs_pkg::FC_09}: r = {1'b1, ppfs_pkg::F_CONV2_TRIG};
      {5'd12, ppfs_pkg::FC_0D}: r = {1'b1, ppfs_pkg::F_SPI_A_MISO};
      {5'd12, ppfs_pkg::FC_10}: r = {1'b1, ppfs_pkg::F_CAN0_RX};
      // (R12) port 2 pin 3 routes
      {5'd13, ppfs_pkg::FC_07}: r = {1'b1, ppfs_pkg::F_CLK_ACC_REF};
      {5'd13, ppfs_pkg::FC_0D}: r = {1'b1, ppfs_pkg::F_SPI_A_MOSI};
      {5'd13, ppfs_pkg::FC_10}: r = {1'b1, ppfs_pkg::F_CAN0_TX};
      // (R13) port 2 pin 4 routes
      {5'd14, ppfs_pkg::FC_05}: r = {1'b1, ppfs_pkg::F_BT2_CLK};
      {5'd14, ppfs_pkg::FC_06}: r = {1'b1, ppfs_pkg::F_BT6_OUT};
      {5'd14, ppfs_pkg::FC_0D}: r = {1'b1, ppfs_pkg::F_SPI_A_CLK};
      {5'd14, ppfs_pkg::FC_1E}: r = {1'b1, ppfs_pkg::F_COMPARATOR0_OUT};
      // (R14) converter start outputs and serial flow control
      {5'd15, ppfs_pkg::FC_09}: r = {1'b1, ppfs_pkg::F_CONV1_START};
      {5'd16, ppfs_pkg::FC_01}: r = {1'b1, ppfs_pkg::F_MF9_A};
      {5'd16, ppfs_pkg::FC_03}: r = {1'b1, ppfs_pkg::F_MF9_A_ALT};
      {5'd16, ppfs_pkg::FC_09}: r = {1'b1, ppfs_pkg::F_CONV0_START};
      {5'd16, ppfs_pkg::FC_0A}: r = {1'b1, ppfs_pkg::F_SER1_FLOW};
      // (R15) port 3 pin 0 routes
      {5'd18, ppfs_pkg::FC_02}: r = {1'b1, ppfs_pkg::F_MF_CLK_D};
      {5'd18, ppfs_pkg::FC_04}: r = {1'b1, ppfs_pkg::F_MF_CLK_D_ALT};
      {5'd18, ppfs_pkg::FC_05}: r = {1'b1, ppfs_pkg::F_BT6_CLK};
      {5'd18, ppfs_pkg::FC_0D}: r = {1'b1, ppfs_pkg::F_SPI_A_SEL0};
      {5'd18, ppfs_pkg::FC_1E}: r = {1'b1, ppfs_pkg::F_COMPARATOR3_OUT};
      // (R16) PWM channel 3 on port 3 pins 2 and 3
      {5'd20, ppfs_pkg::FC_14}: r = {1'b1, ppfs_pkg::F_PWM3_A};
      {5'd20, ppfs_pkg::FC_16}: r = {1'b1, ppfs_pkg::F_PWM3_A_ALT};
      {5'd21, ppfs_pkg::FC_14}: r = {1'b1, ppfs_pkg::F_PWM3_B};
      {5'd21, ppfs_pkg::FC_16}: r = {1'b1, ppfs_pkg::F_PWM3_B_ALT};
      // (R17) port 3 pin 4 routes
      {5'd22, ppfs_pkg::FC_11}: r = {1'b1, ppfs_pkg::F_USB_OVERCUR};
      {5'd22, ppfs_pkg::FC_14}: r = {1'b1, ppfs_pkg::F_PWM_CONV_MON1};
      {5'd22, ppfs_pkg::FC_15}: r = {1'b1, ppfs_pkg::F_PWM_TRIG_B};
      // (R1) (R22) zero and unlisted codes route nothing
      default:                  r = '0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus front end and pin synchroniser

  logic                 wr_en;
  logic [7:0]           wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;
  logic                 wr_ok;
  logic [7:0]           rd_addr;
  logic [31:0]          rd_data;
  logic                 rd_ok;
  logic [NP-1:0]        pin_s;

  ppfs_axil_slave #(.AW(ppfs_pkg::AW)) u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awaddr  (s_axil_awaddr),
    .awvalid (s_axil_awvalid),
    .awready (s_axil_awready),
    .wdata   (s_axil_wdata),
    .wstrb   (s_axil_wstrb),
    .wvalid  (s_axil_wvalid),
    .wready  (s_axil_wready),
    .bresp   (s_axil_bresp),
    .bvalid  (s_axil_bvalid),
    .bready  (s_axil_bready),
    .araddr  (s_axil_araddr),
    .arvalid (s_axil_arvalid),
    .arready (s_axil_arready),
    .rdata   (s_axil_rdata),
    .rresp   (s_axil_rresp),
    .rvalid  (s_axil_rvalid),
    .rready  (s_axil_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  ppfs_sync2 #(.W(NP)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (pin_in),
    .q       (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin control registers

  logic [7:0]    ctl_q [NP];
  logic [NP-1:0] wr_hit;
  logic [NP-1:0] rd_hit;

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      wr_hit[i] = (wr_addr == ppfs_pkg::PIN_OFS[i]);
      rd_hit[i] = (rd_addr == ppfs_pkg::PIN_OFS[i]);
    end
  end

  // status words are read-only, a write there answers with an error
  assign wr_ok = |wr_hit;

  // only the low byte lane carries control bits
  generate
    for (genvar g = 0; g < NP; g++) begin : g_ctl
      // (R3) analog select only exists on port 2 pins
      localparam logic [7:0] MASK = ppfs_pkg::ANALOG_INPUT_SELECT_PINS[g] ? ppfs_pkg::CTL_MASK_A : ppfs_pkg::CTL_MASK;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctl_q[g] <= ppfs_pkg::CTL_RESET;
        end else if (ce && wr_en && wr_hit[g] && wr_strb[0]) begin
          ctl_q[g] <= wr_data[7:0] & MASK;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // per-pin resolution

  logic [FW:0]   sel    [NP];
  logic [NP-1:0] analog_input_select;
  logic [NP-1:0] live;
  logic [NP-1:0] unlisted;
  logic [NP-1:0] shadow;

  // each pin resolves its own code
  generate
    for (genvar g = 0; g < NP; g++) begin : g_sel
      assign sel[g]      = route(5'(g), ctl_q[g][FW-1:0]);
      // (R3) analog use removes the pin from digital routing
      assign analog_input_select[g]     = ctl_q[g][ppfs_pkg::ANALOG_INPUT_SELECT_BIT];
      assign live[g]     = sel[g][FW] & ~analog_input_select[g];
      // (R22) nonzero codes without a route
      assign unlisted[g] = (ctl_q[g][FW-1:0] != ppfs_pkg::FC_HIZ) & ~sel[g][FW];
    end
  endgenerate

  // a pin whose slot is already taken by a lower pin is shadowed
  always_comb begin
    shadow = '0;
    for (int i = 1; i < NP; i++) begin
      for (int j = 0; j < i; j++) begin
        if (live[i] && live[j] && sel[i][FW-1:0] == sel[j][FW-1:0]) begin
          shadow[i] = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read

  // control words read back masked, status words follow
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (rd_hit[i]) begin
        rd_data = {24'h00_0000, ctl_q[i]};
        rd_ok   = 1'b1;
      end
    end
    case (rd_addr)
      ppfs_pkg::STAT_ROUTED_OFS: begin
        rd_data = {9'h000, live};
        rd_ok   = 1'b1;
      end
      ppfs_pkg::STAT_SHADOW_OFS: begin
        rd_data = {9'h000, shadow};
        rd_ok   = 1'b1;
      end
      ppfs_pkg::STAT_UNLISTED_OFS: begin
        rd_data = {9'h000, unlisted};
        rd_ok   = 1'b1;
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive and peripheral inputs

  localparam int NIRQ_W = ppfs_pkg::NIRQ - 1;
  logic [NP-1:0]   pin_out_d;
  logic [NP-1:0]   pin_oe_d;
  logic [NF-1:0]   periph_in_d;
  logic [NIRQ_W:0] irq_tmp;
  logic [ppfs_pkg::NIRQ-1:0] ext_irq_d;

  // a slot routed to several pins drives all of them
  // (R1) selected slot drives the pin, otherwise high impedance
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      pin_out_d[i] = live[i] & periph_out[sel[i][FW-1:0]];
      pin_oe_d[i]  = live[i] & periph_oe[sel[i][FW-1:0]];
    end
  end

  // lowest routed pin wins when one slot sits on several pins
  always_comb begin
    periph_in_d = '0;
    for (int f = 0; f < NF; f++) begin
      for (int i = NP - 1; i >= 0; i--) begin
        if (live[i] && sel[i][FW-1:0] == FW'(f)) begin
          periph_in_d[f] = pin_s[i];
        end
      end
    end
  end

  // a pin in analog use never raises its line
  // (R2) (R18) (R19) (R20) interrupt select feeds the mapped line
  always_comb begin
    irq_tmp = '0;
    for (int i = 0; i < NP; i++) begin
      if (ctl_q[i][ppfs_pkg::IRQ_INPUT_SELECT_BIT] && !analog_input_select[i] && ppfs_pkg::PIN_IRQ[i] != ppfs_pkg::IRQ_NONE) begin
        irq_tmp[ppfs_pkg::PIN_IRQ[i][3:0]] = irq_tmp[ppfs_pkg::PIN_IRQ[i][3:0]] | pin_s[i];
      end
    end
    ext_irq_d = irq_tmp;
  end

  // pin and line levels all change on one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out   <= '0;
      pin_oe    <= '0;
      periph_in <= '0;
      ext_irq   <= '0;
      analog_en <= '0;
    end else if (ce) begin
      pin_out   <= pin_out_d;
      pin_oe    <= pin_oe_d;
      periph_in <= periph_in_d;
      ext_irq   <= ext_irq_d;
      // (R3) analog dedication flag per pin
      analog_en <= analog_input_select;
    end
  end
endmodule // ppfs_top

// ### src/ppfs_pkg.sv
// ppfs_pkg: constants for the port pin function select block
// assumes 32-bit AXI4-Lite access, one aligned word per register
//
// Behaviour
// (R1) bits 5:0 hold the function code; code zero routes nothing, pin high impedance
// (R2) interrupt select bit set makes the pin feed its external interrupt line
// (R3) analog select bit set dedicates the pin to analog use, else digital
// (R4) P0.0: 07h clock accuracy reference, 09h converter 1 start, 1Eh comparator 0
// (R5) P0.1: 07h output disable 12, 09h converter 2 start, 14h-17h PWM triggers a-d
// (R6) P1.0: 02h timer clock D, 04h its alternate, 05h byte timer 3 reset
// (R7) P1.1: 05h byte timer 3 out, 07h output disable 9, 08h timer 9 signal D
// (R8) P1.2-P1.4: 14h low PWM channel A, 15h higher channel A, 16h alternate
// (R9) P2.0: 05h byte timer 4 reset, 09h converter 0 trigger, 0Dh SPI A clock
// (R10) P2.1: 05h byte timer 4 clock, 0Dh SPI A master out, 1Eh comparator 5
// (R11) P2.2: 09h converter 2 trigger, 0Dh SPI A master in, 10h CAN 0 receive
// (R12) P2.3: 07h clock accuracy reference, 0Dh SPI A master out, 10h CAN 0 transmit
// (R13) P2.4: 05h byte timer 2 clock, 06h byte timer 6 out, 0Dh SPI A clock
// (R14) 09h: converter 1 start on P2.5, converter 0 start on P2.6; P2.6 0Ah serial flow
// (R15) P3.0: 05h byte timer 6 clock, 0Dh SPI A select 0, 1Eh comparator 3
// (R16) P3.2/P3.3: 14h PWM channel 3 A or B, 16h its alternate
// (R17) P3.4: 11h USB overcurrent, 14h PWM start monitor 1, 15h PWM trigger b
// (R18) interrupt select: P0.0 drives line 2, P0.1 drives line 4
// (R19) interrupt select: P1.2 through P1.7 drive lines 9 through 14
// (R20) interrupt select: P2.2 and P2.5 drive line 10, P2.3 and P2.6 line 11
// (R21) P0.0: 01h timer 9 signal A, 03h its alternate
// (R22) unlisted codes connect nothing, pin behaves as high impedance
package ppfs_pkg;
  localparam int NPINS = 23;
  localparam int NFUNC = 49;
  localparam int NIRQ  = 16;
  localparam int AW    = 8;
  localparam int FW    = 6;
  localparam int IRQ_INPUT_SELECT_BIT = 6;
  localparam int ANALOG_INPUT_SELECT_BIT = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_MASK  = 8'h7F;
  localparam logic [7:0] CTL_MASK_A = 8'hFF;
  // pins of port 2 carry the analog select bit
  localparam logic [NPINS-1:0] ANALOG_INPUT_SELECT_PINS = 23'h03FC00;
  localparam logic [AW-1:0] STAT_ROUTED_OFS  = 8'h80;
  localparam logic [AW-1:0] STAT_SHADOW_OFS  = 8'h84;
  localparam logic [AW-1:0] STAT_UNLISTED_OFS = 8'h88;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // pin index order: P00 P01 P10..P17 P20..P27 P30..P34
  localparam logic [AW-1:0] PIN_OFS [NPINS] = '{
    8'h00, 8'h04,
    8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C,
    8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C,
    8'h60, 8'h64, 8'h68, 8'h6C, 8'h70};
  localparam logic [4:0] IRQ_NONE = 5'h1F;
  localparam logic [4:0] PIN_IRQ [NPINS] = '{
    5'h02, 5'h04,
    5'h00, 5'h01, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E,
    5'h07, 5'h06, 5'h0A, 5'h0B, 5'h04, 5'h0A, 5'h0B, 5'h0F,
    5'h07, 5'h06, 5'h0C, 5'h0D, 5'h03};
  localparam logic [FW-1:0] FC_HIZ = 6'h00, FC_01 = 6'h01, FC_02 = 6'h02, FC_03 = 6'h03;
  localparam logic [FW-1:0] FC_04 = 6'h04, FC_05 = 6'h05, FC_06 = 6'h06, FC_07 = 6'h07;
  localparam logic [FW-1:0] FC_08 = 6'h08, FC_09 = 6'h09, FC_0A = 6'h0A, FC_0D = 6'h0D;
  localparam logic [FW-1:0] FC_10 = 6'h10, FC_11 = 6'h11, FC_14 = 6'h14, FC_15 = 6'h15;
  localparam logic [FW-1:0] FC_16 = 6'h16, FC_17 = 6'h17, FC_1E = 6'h1E;
  // peripheral function slots
  localparam logic [FW-1:0] F_CLK_ACC_REF = 6'h00, F_CONV1_START = 6'h01, F_COMPARATOR0_OUT = 6'h02;
  localparam logic [FW-1:0] F_MF9_A = 6'h03, F_MF9_A_ALT = 6'h04, F_OUT_DIS12 = 6'h05;
  localparam logic [FW-1:0] F_CONV2_START = 6'h06, F_PWM_TRIG_A = 6'h07, F_PWM_TRIG_B = 6'h08;
  localparam logic [FW-1:0] F_PWM_TRIG_C = 6'h09, F_PWM_TRIG_D = 6'h0A, F_MF_CLK_D = 6'h0B;
  localparam logic [FW-1:0] F_MF_CLK_D_ALT = 6'h0C, F_BT3_RESET = 6'h0D, F_BT3_OUT = 6'h0E;
  localparam logic [FW-1:0] F_OUT_DIS9 = 6'h0F, F_MF9_D = 6'h10, F_PWM0_A = 6'h11;
  localparam logic [FW-1:0] F_PWM7_A = 6'h12, F_PWM0_A_ALT = 6'h13, F_PWM1_A = 6'h14;
  localparam logic [FW-1:0] F_PWM8_A = 6'h15, F_PWM1_A_ALT = 6'h16, F_PWM2_A = 6'h17;
  localparam logic [FW-1:0] F_PWM9_A = 6'h18, F_PWM2_A_ALT = 6'h19, F_BT4_RESET = 6'h1A;
  localparam logic [FW-1:0] F_CONV0_TRIG = 6'h1B, F_SPI_A_CLK = 6'h1C, F_BT4_CLK = 6'h1D;
  localparam logic [FW-1:0] F_SPI_A_MOSI = 6'h1E, F_COMPARATOR5_OUT = 6'h1F, F_CONV2_TRIG = 6'h20;
  localparam logic [FW-1:0] F_SPI_A_MISO = 6'h21, F_CAN0_RX = 6'h22, F_CAN0_TX = 6'h23;
  localparam logic [FW-1:0] F_BT2_CLK = 6'h24, F_BT6_OUT = 6'h25, F_CONV0_START = 6'h26;
  localparam logic [FW-1:0] F_SER1_FLOW = 6'h27, F_BT6_CLK = 6'h28, F_SPI_A_SEL0 = 6'h29;
  localparam logic [FW-1:0] F_COMPARATOR3_OUT = 6'h2A, F_PWM3_A = 6'h2B, F_PWM3_A_ALT = 6'h2C;
  localparam logic [FW-1:0] F_PWM3_B = 6'h2D, F_PWM3_B_ALT = 6'h2E, F_USB_OVERCUR = 6'h2F;
  localparam logic [FW-1:0] F_PWM_CONV_MON1 = 6'h30;
endpackage

// ### src/ppfs_sync2.sv
// ppfs_sync2: two-flop synchroniser for a vector of pin levels
// assumes each bit is an independent asynchronous level
`timescale 1ns/1ns
module ppfs_sync2 #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // ppfs_sync2

// ### src/ppfs_axil_slave.sv
// ppfs_axil_slave: AXI4-Lite protocol front end, one write and one read
// assumes the owner decodes addresses and returns hit flags combinationally
`timescale 1ns/1ns
module ppfs_axil_slave #(
  parameter int AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  output logic               wr_en,
  output logic [AW-1:0]      wr_addr,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_ok,
  output logic [AW-1:0]      rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_ok
);
  localparam logic [1:0] RESP_OKAY_C = ppfs_pkg::RESP_OKAY;
  localparam logic [1:0] RESP_ERR_C  = ppfs_pkg::RESP_SLVERR;

  logic aw_hold_q;
  logic w_hold_q;

  assign awready = ce & ~aw_hold_q & ~bvalid;
  assign wready  = ce & ~w_hold_q & ~bvalid;
  assign arready = ce & ~rvalid;
  assign wr_en   = ce & aw_hold_q & w_hold_q & ~bvalid;
  assign rd_addr = araddr;

  // address and data are taken in either order and held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      wr_addr   <= '0;
      wr_data   <= '0;
      wr_strb   <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        wr_addr   <= awaddr;
      end else if (wr_en) begin
        aw_hold_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        wr_data  <= wdata;
        wr_strb  <= wstrb;
      end else if (wr_en) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY_C;
    end else if (ce) begin
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? RESP_OKAY_C : RESP_ERR_C;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY_C;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_ok ? rd_data : 32'h0000_0000;
        rresp  <= rd_ok ? RESP_OKAY_C : RESP_ERR_C;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // ppfs_axil_slave

// ### testbench/ppfs_periph_model.sv
// ppfs_periph_model: on-chip peripherals and package pins beside ppfs_top
// assumes the bench sets external pin levels on pin_lvl
`timescale 1ns/1ns
module ppfs_periph_model (
  input  logic [22:0] pin_lvl,
  input  logic [22:0] pin_out,
  input  logic [22:0] pin_oe,
  output logic [48:0] periph_out,
  output logic [48:0] periph_oe,
  output logic [22:0] pin_in
);
  assign periph_out = '1;
  // only the converter 1 start and comparator 0 slots enable their drivers, all other slots keep them off
  assign periph_oe = (49'h1 << ppfs_pkg::F_CONV1_START) | (49'h1 << ppfs_pkg::F_COMPARATOR0_OUT);
  // a driven pin shows its own level, otherwise the external level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_lvl);
endmodule // ppfs_periph_model

// ### testbench/ppfs_top_properties.sv
// ppfs_top_properties: handshake and pin state checks on ppfs_top ports
// assumes one clock aclk with synchronous active-low aresetn
`timescale 1ns/1ns
module ppfs_top_properties (
  input logic        aclk,
  input logic        aresetn,
  input logic        ce,
  input logic        s_axil_awready,
  input logic        s_axil_bvalid,
  input logic        s_axil_bready,
  input logic        s_axil_arready,
  input logic        s_axil_rvalid,
  input logic        s_axil_rready,
  input logic [22:0] pin_oe,
  input logic [22:0] analog_en
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_wr_done: assert property (s_axil_bvalid && s_axil_bready && ce |=> !s_axil_bvalid) else $error("bvalid held");
  a_rd_done: assert property (s_axil_rvalid && s_axil_rready && ce |=> !s_axil_rvalid) else $error("rvalid held");
  a_rd_block: assert property (s_axil_rvalid |-> !s_axil_arready) else $error("arready with rvalid");
  a_wr_block: assert property (s_axil_bvalid |-> !s_axil_awready) else $error("awready with bvalid");
  a_ce_freeze: assert property (!ce |-> !s_axil_awready && !s_axil_arready) else $error("ready while frozen");
  a_analog_port2: assert property ((analog_en & ~ppfs_pkg::ANALOG_INPUT_SELECT_PINS) == '0)
    else $error("analog off port 2");
  a_analog_quiet: assert property ((analog_en & $past(analog_en, 2) & pin_oe) == '0)
    else $error("analog pin driven");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> pin_oe == '0 && analog_en == '0)
    else $error("not idle after reset");
endmodule // ppfs_top_properties
bind ppfs_top ppfs_top_properties u_props (.*);

// ### testbench/port_pin_function_select_tb_top.sv
// port_pin_function_select_tb_top: register-driven checks of pin routing
// assumes ppfs_top with the peripheral model and the bound checker
`timescale 1ns/1ns
module port_pin_function_select_tb_top;
  localparam logic [1:0] OK = ppfs_pkg::RESP_OKAY, ER = ppfs_pkg::RESP_SLVERR;
  logic aclk = '0, aresetn = '0, ce = '1, s_axil_awvalid = '0, s_axil_wvalid = '0, s_axil_bready = '0;
  logic s_axil_arvalid = '0, s_axil_rready = '0, s_axil_awready, s_axil_wready, s_axil_bvalid;
  logic s_axil_arready, s_axil_rvalid;
  logic [7:0] s_axil_awaddr = '0, s_axil_araddr = '0;
  logic [31:0] s_axil_wdata = '0, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [22:0] pin_in, pin_out, pin_oe, analog_en, pin_lvl = '1;
  logic [48:0] periph_out, periph_oe, periph_in;
  logic [15:0] ext_irq;
  int n_mismatch = 0, checked = 0;
  always #2 aclk = ~aclk;
  ppfs_top u_dut (.*);
  ppfs_periph_model u_periph (.*);
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // handshake flags are read before each edge, released by that edge
  task automatic xfer(bit w, logic [7:0] a, logic [7:0] d, logic [1:0] er);
    logic aw, wd, ar, dn;
    logic [31:0] q;
    logic [1:0] r;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_araddr <= a;
    s_axil_wdata <= {24'h000000, d};
    s_axil_awvalid <= w;
    s_axil_wvalid <= w;
    s_axil_bready <= w;
    s_axil_arvalid <= !w;
    s_axil_rready <= !w;
    do begin
      @(negedge aclk);
      {aw, wd, ar} = {s_axil_awready, s_axil_wready, s_axil_arready};
      dn = w ? s_axil_bvalid : s_axil_rvalid;
      r = w ? s_axil_bresp : s_axil_rresp;
      q = s_axil_rdata;
      @(posedge aclk);
      if (aw) s_axil_awvalid <= '0;
      if (wd) s_axil_wvalid <= '0;
      if (ar) s_axil_arvalid <= '0;
    end while (!dn);
    s_axil_bready <= '0;
    s_axil_rready <= '0;
    chk("resp", r, er);
    if (!w) chk("rdata", q, {24'h000000, d});
  endtask
  task automatic cfg(int i, logic [7:0] d);
    xfer(1, ppfs_pkg::PIN_OFS[i], d, OK);
    repeat (4) @(posedge aclk);
  endtask
  task automatic complete_run;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(0, 8'h00, 8'h00, OK);
    cfg(0, 8'h09);
    chk("oe0", pin_oe[0], 1);
    chk("out0", pin_out[0], 1);
    xfer(0, 8'h80, 8'h01, OK);
    cfg(0, 8'h05);
    chk("oe0", pin_oe[0], 0);
    cfg(0, 8'h40);
    chk("ext_irq_line2", ext_irq[2], 1);
    cfg(0, 8'h80);
    chk("ext_irq_line2", ext_irq[2], 0);
    xfer(0, 8'h00, 8'h00, OK);
    $display("test basic done");
    for (int i = 0; i < 6; i++) begin
      cfg(4 + i, 8'h40);
      chk("irq", ext_irq[9 + i], 1);
      cfg(4 + i, 8'h00);
    end
    cfg(15, 8'h40);
    chk("ext_irq_line10", ext_irq[10], 1);
    cfg(16, 8'h40);
    chk("ext_irq_line11", ext_irq[11], 1);
    $display("test irq done");
    cfg(10, 8'h89);
    xfer(0, 8'h40, 8'h89, OK);
    chk("an", analog_en[10], 1);
    chk("trig", periph_in[ppfs_pkg::F_CONV0_TRIG], 0);
    cfg(10, 8'h09);
    chk("trig", periph_in[ppfs_pkg::F_CONV0_TRIG], 1);
    $display("test route done");
    xfer(1, 8'h08, 8'h5A, ER);
    xfer(0, 8'h08, 8'h00, ER);
    ce <= 1'b0;
    repeat (2) @(posedge aclk);
    ce <= 1'b1;
    $display("test bus done");
    complete_run;
  end
  initial begin
    #20000;
    n_mismatch++;
    complete_run;
  end
endmodule // port_pin_function_select_tb_top
